// ### rtl/hafb_frame_rx.sv
// Device-side receiver and checker for host API frames on a byte stream.
`timescale 1ns/1ps
`default_nettype none
module hafb_frame_rx #(
    parameter int unsigned TIMEOUT_CYC = hafb_pkg::DRSP_TIMEOUT_CYC
) (
    input  wire logic        clk_sys_i,
    input  wire logic        rstn_i,
    input  wire logic        in_valid_i,
    input  wire logic [7:0]  in_byte_i,
    input  wire logic        dev_req_i,
    input  wire logic [7:0]  dev_req_id_i,
    output logic             done_o,
    output logic             good_o,
    output logic [7:0]       type_o,
    output logic [7:0]       fid_o,
    output logic             status_wanted_o,
    output logic             tx4_tcp_o,
    output logic             tx4_close_o,
    output logic [15:0]      tx4_srcport_o,
    output logic             tx4_too_long_o,
    output logic             opt_err_o,
    output logic [1:0]       sd_mode_o,
    output logic             sd_ctype_err_o,
    output logic             dr_mismatch_o,
    output logic             dr_unexpected_o,
    output logic             dr_timeout_o,
    output logic             data_valid_o,
    output logic [7:0]       data_o
);
    hafb_pkg::hafb_state_t state_r;
    logic [15:0] len_r;
    logic [15:0] idx_r;
    logic [7:0]  type_r;
    logic [7:0]  fid_r;
    logic [15:0] src_r;
    logic        tcp_r;
    logic [7:0]  txopt_r;
    logic [7:0]  plen_r;
    logic [7:0]  ctlen_r;
    logic [7:0]  mode_byte_r;
    logic [7:0]  reqid_r;
    logic        rsvd_err_r;
    logic        pending_r;
    logic [7:0]  exp_id_r;
    logic [hafb_pkg::TIMER_W-1:0] timer_r;
    logic [7:0]  csum_expect;
    logic        take;
    logic        last_body;
    logic        known_type;
    logic        csum_ok;
    logic        dr_accept;
    logic [15:0] ctl_ofs;
    logic [15:0] opt_ofs;
    logic [15:0] data_start;

    default clocking cb_sys @(posedge clk_sys_i);
    endclocking
    default disable iff (!rstn_i);

    assign take       = in_valid_i;
    assign last_body  = (idx_r == len_r + 16'h0002);
    assign known_type = (type_r == hafb_pkg::TYPE_TX4) || (type_r == hafb_pkg::TYPE_SEND) ||
                        (type_r == hafb_pkg::TYPE_DRSP);
    assign csum_ok    = (in_byte_i == csum_expect);
    assign ctl_ofs    = hafb_pkg::OFS_PATH + {8'h00, plen_r};
    assign opt_ofs    = ctl_ofs + {8'h00, ctlen_r} + 16'h0002;
    assign dr_accept  = (state_r == hafb_pkg::S_CSUM) && take && csum_ok &&
                        (type_r == hafb_pkg::TYPE_DRSP) && pending_r && (reqid_r == exp_id_r);

    // Payload start differs per frame type; unknown types carry no payload.
    always_comb begin
        case (type_r)
            hafb_pkg::TYPE_TX4:  data_start = hafb_pkg::OFS_TX4_DATA;
            hafb_pkg::TYPE_SEND: data_start = opt_ofs + 16'h0001;
            hafb_pkg::TYPE_DRSP: data_start = hafb_pkg::OFS_DR_DATA;
            default:             data_start = 16'hFFFF;
        endcase
    end

    hafb_csum u_csum (
        .clk_sys_i (clk_sys_i),
        .rstn_i    (rstn_i),
        .clr_i     ((state_r == hafb_pkg::S_IDLE) && take),
        .add_i     ((state_r == hafb_pkg::S_BODY) && take),
        .byte_i    (in_byte_i),
        .expect_o  (csum_expect)
    );

    // Framing: a byte other than the delimiter while idle is dropped, which resynchronises after noise.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            state_r <= hafb_pkg::S_IDLE;
            len_r   <= 16'h0000;
            idx_r   <= 16'h0000;
        end else if (take) begin
            case (state_r)
                hafb_pkg::S_IDLE: begin
                    if (in_byte_i == hafb_pkg::DELIM) state_r <= hafb_pkg::S_LEN_HI;
                end
                hafb_pkg::S_LEN_HI: begin
                    len_r[15:8] <= in_byte_i;
                    state_r     <= hafb_pkg::S_LEN_LO;
                end
                hafb_pkg::S_LEN_LO: begin
                    len_r[7:0] <= in_byte_i;
                    idx_r      <= hafb_pkg::OFS_TYPE;
                    if ({len_r[15:8], in_byte_i} == 16'h0000) begin
                        state_r <= hafb_pkg::S_CSUM;
                    end else begin
                        state_r <= hafb_pkg::S_BODY;
                    end
                end
                hafb_pkg::S_BODY: begin
                    idx_r <= idx_r + 16'h0001;
                    if (last_body) state_r <= hafb_pkg::S_CSUM;
                end
                hafb_pkg::S_CSUM: begin
                    state_r <= hafb_pkg::S_IDLE;
                end
                default: begin
                    state_r <= hafb_pkg::S_IDLE;
                end
            endcase
        end
    end

    // Header field capture by frame offset.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            type_r      <= 8'h00;
            fid_r       <= 8'h00;
            src_r       <= 16'h0000;
            tcp_r       <= 1'b0;
            txopt_r     <= 8'h00;
            plen_r      <= 8'h00;
            ctlen_r     <= 8'h00;
            mode_byte_r <= 8'h00;
            reqid_r     <= 8'h00;
            rsvd_err_r  <= 1'b0;
        end else if (take && (state_r == hafb_pkg::S_LEN_LO)) begin
            type_r     <= 8'h00;
            rsvd_err_r <= 1'b0;
        end else if (take && (state_r == hafb_pkg::S_BODY)) begin
            if (idx_r == hafb_pkg::OFS_TYPE) type_r <= in_byte_i;
            if (idx_r == hafb_pkg::OFS_FID) fid_r <= in_byte_i;
            if (type_r == hafb_pkg::TYPE_TX4) begin
                if (idx_r == hafb_pkg::OFS_SRC_HI) src_r[15:8] <= in_byte_i;
                if (idx_r == hafb_pkg::OFS_SRC_LO) src_r[7:0] <= in_byte_i;
                if (idx_r == hafb_pkg::OFS_PROTO) tcp_r <= (in_byte_i == hafb_pkg::PROTO_TCP);
                if (idx_r == hafb_pkg::OFS_TXOPT) txopt_r <= in_byte_i;
            end
            if (type_r == hafb_pkg::TYPE_SEND) begin
                if (idx_r == hafb_pkg::OFS_PLEN) plen_r <= in_byte_i;
                if (idx_r == ctl_ofs) ctlen_r <= in_byte_i;
                if (idx_r == opt_ofs) mode_byte_r <= in_byte_i;
            end
            if (type_r == hafb_pkg::TYPE_DRSP) begin
                if (idx_r == hafb_pkg::OFS_REQID) reqid_r <= in_byte_i;
                if (idx_r == hafb_pkg::OFS_RSVD) rsvd_err_r <= (in_byte_i != 8'h00);
            end
        end
    end

    // Payload passes straight through; a bad checksum is only known afterwards at done_o.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            data_valid_o <= 1'b0;
            data_o       <= 8'h00;
        end else begin
            data_valid_o <= take && (state_r == hafb_pkg::S_BODY) && (idx_r > hafb_pkg::OFS_TYPE) &&
                            (idx_r >= data_start);
            data_o       <= in_byte_i;
        end
    end

    // Frame verdict on the checksum byte.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            done_o          <= 1'b0;
            good_o          <= 1'b0;
            type_o          <= 8'h00;
            fid_o           <= 8'h00;
            status_wanted_o <= 1'b0;
            tx4_tcp_o       <= 1'b0;
            tx4_close_o     <= 1'b0;
            tx4_srcport_o   <= 16'h0000;
            tx4_too_long_o  <= 1'b0;
            opt_err_o       <= 1'b0;
            sd_mode_o       <= hafb_pkg::MODE_OVERWRITE;
            sd_ctype_err_o  <= 1'b0;
            dr_mismatch_o   <= 1'b0;
            dr_unexpected_o <= 1'b0;
        end else begin
            done_o <= take && (state_r == hafb_pkg::S_CSUM);
            if (take && (state_r == hafb_pkg::S_CSUM)) begin
                good_o          <= csum_ok && known_type;
                type_o          <= type_r;
                fid_o           <= fid_r;
                status_wanted_o <= (fid_r != 8'h00);
                tx4_tcp_o       <= tcp_r;
                tx4_close_o     <= tcp_r && txopt_r[hafb_pkg::TXOPT_CLOSE];
                tx4_srcport_o   <= src_r;
                tx4_too_long_o  <= (type_r == hafb_pkg::TYPE_TX4) && (len_r > hafb_pkg::TX4_LEN_MAX);
                opt_err_o       <= ((type_r == hafb_pkg::TYPE_TX4) && ((txopt_r & hafb_pkg::TXOPT_RSVD) != 8'h00)) ||
                                   ((type_r == hafb_pkg::TYPE_SEND) && (mode_byte_r > hafb_pkg::MODE_MAX)) ||
                                   ((type_r == hafb_pkg::TYPE_DRSP) && rsvd_err_r);
                sd_mode_o       <= mode_byte_r[1:0];
                sd_ctype_err_o  <= (type_r == hafb_pkg::TYPE_SEND) && (ctlen_r > hafb_pkg::CTYPE_MAX);
                dr_mismatch_o   <= csum_ok && (type_r == hafb_pkg::TYPE_DRSP) && pending_r &&
                                   (reqid_r != exp_id_r);
                dr_unexpected_o <= csum_ok && (type_r == hafb_pkg::TYPE_DRSP) && !pending_r;
            end
        end
    end

    // Outstanding device request and its reply deadline; a new request wins over a reply in the same cycle.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            pending_r    <= 1'b0;
            exp_id_r     <= 8'h00;
            timer_r      <= '0;
            dr_timeout_o <= 1'b0;
        end else begin
            dr_timeout_o <= 1'b0;
            if (dev_req_i) begin
                pending_r <= (dev_req_id_i != 8'h00);
                exp_id_r  <= dev_req_id_i;
                timer_r   <= TIMEOUT_CYC[hafb_pkg::TIMER_W-1:0];
            end else if (dr_accept) begin
                pending_r <= 1'b0;
            end else if (pending_r) begin
                if (timer_r <= 1) begin
                    pending_r    <= 1'b0;
                    dr_timeout_o <= 1'b1;
                end else begin
                    timer_r <= timer_r - 1'b1;
                end
            end
        end
    end

    property p_delim;
        (state_r == hafb_pkg::S_IDLE) && take && (in_byte_i != hafb_pkg::DELIM) |=> (state_r == hafb_pkg::S_IDLE);
    endproperty
    a_delim: assert property (p_delim) else $error("non-delimiter byte left idle");
    property p_csum_bad;
        (state_r == hafb_pkg::S_CSUM) && take && !csum_ok |=> done_o && !good_o;
    endproperty
    a_csum_bad: assert property (p_csum_bad) else $error("bad checksum frame not dropped");
    property p_len_body;
        (state_r == hafb_pkg::S_LEN_LO) && take && ({len_r[15:8], in_byte_i} == 16'h0002) ##1 take [*2]
        |=> (state_r == hafb_pkg::S_CSUM);
    endproperty
    a_len_body: assert property (p_len_body) else $error("length field not honoured");
    property p_status;
        done_o |-> (status_wanted_o == (fid_o != 8'h00));
    endproperty
    a_status: assert property (p_status) else $error("status request does not follow frame id");
    property p_close_udp;
        done_o && !tx4_tcp_o |-> !tx4_close_o;
    endproperty
    a_close_udp: assert property (p_close_udp) else $error("close flag set for datagram");
    property p_too_long;
        (state_r == hafb_pkg::S_CSUM) && take && (type_r == hafb_pkg::TYPE_TX4) && (len_r == 16'h0585)
        |=> tx4_too_long_o;
    endproperty
    a_too_long: assert property (p_too_long) else $error("payload over 1400 not flagged");
    property p_ctype;
        (state_r == hafb_pkg::S_CSUM) && take && (type_r == hafb_pkg::TYPE_SEND) && (ctlen_r == 8'h11)
        |=> sd_ctype_err_o;
    endproperty
    a_ctype: assert property (p_ctype) else $error("long content type not flagged");
    property p_timeout;
        pending_r && (timer_r == 28'h0000001) && !dev_req_i && !dr_accept |=> dr_timeout_o && !pending_r;
    endproperty
    a_timeout: assert property (p_timeout) else $error("reply deadline missed without timeout");
    // A fresh request or an expiring deadline may legally drop the pending reply, so both are excluded.
    property p_mismatch;
        (state_r == hafb_pkg::S_CSUM) && take && csum_ok && (type_r == hafb_pkg::TYPE_DRSP) && pending_r &&
        (reqid_r != exp_id_r) && !dev_req_i && (timer_r > 28'h0000002) ##1 !dev_req_i |-> dr_mismatch_o ##1 pending_r;
    endproperty
    a_mismatch: assert property (p_mismatch) else $error("request id mismatch not reported");
    property p_data_src;
        data_valid_o |-> ($past(state_r) == hafb_pkg::S_BODY) && (data_o == $past(in_byte_i));
    endproperty
    a_data_src: assert property (p_data_src) else $error("payload byte not from frame body");
    property p_zero_id;
        dev_req_i && (dev_req_id_i == 8'h00) |=> !pending_r;
    endproperty
    a_zero_id: assert property (p_zero_id) else $error("request id zero left a reply pending");
    c_tx4_good: cover property (done_o && good_o && (type_o == hafb_pkg::TYPE_TX4));
    c_send_good: cover property (done_o && good_o && (type_o == hafb_pkg::TYPE_SEND));
    c_drsp_ok: cover property (dr_accept);
    c_timeout: cover property (dr_timeout_o);
endmodule
`default_nettype wire

// ### rtl/hafb_pkg.sv
// Package with the frame layout constants, timing constants and parser states of the host API frame builder.
package hafb_pkg;
    localparam logic [7:0]  DELIM          = 8'h7E;
    localparam logic [7:0]  TYPE_TX4       = 8'h20;
    localparam logic [7:0]  TYPE_SEND      = 8'h28;
    localparam logic [7:0]  TYPE_DRSP      = 8'h2A;
    localparam logic [7:0]  TYPE_DREQ      = 8'hB9;
    localparam logic [7:0]  CSUM_BASE      = 8'hFF;
    localparam logic [15:0] OFS_TYPE       = 16'h0003;
    localparam logic [15:0] OFS_FID        = 16'h0004;
    localparam logic [15:0] OFS_SRC_HI     = 16'h000B;
    localparam logic [15:0] OFS_SRC_LO     = 16'h000C;
    localparam logic [15:0] OFS_PROTO      = 16'h000D;
    localparam logic [15:0] OFS_TXOPT      = 16'h000E;
    localparam logic [15:0] OFS_TX4_DATA   = 16'h000F;
    localparam logic [15:0] OFS_PLEN       = 16'h0005;
    localparam logic [15:0] OFS_PATH       = 16'h0006;
    localparam logic [15:0] OFS_REQID      = 16'h0005;
    localparam logic [15:0] OFS_RSVD       = 16'h0006;
    localparam logic [15:0] OFS_DR_DATA    = 16'h0007;
    localparam logic [15:0] MAX_PAYLOAD_QUERY_SIZE = 16'h0570;
    localparam logic [15:0] TX4_EXTRA      = 16'h0008;
    localparam logic [15:0] TX4_MAX_DATA   = MAX_PAYLOAD_QUERY_SIZE + TX4_EXTRA;
    localparam logic [15:0] TX4_LEN_MAX    = OFS_TX4_DATA - OFS_TYPE + TX4_MAX_DATA;
    localparam logic [7:0]  PROTO_UDP      = 8'h00;
    localparam logic [7:0]  PROTO_TCP      = 8'h01;
    localparam int unsigned TXOPT_CLOSE    = 1;
    localparam logic [7:0]  TXOPT_RSVD     = 8'hFD;
    localparam logic [7:0]  CTYPE_MAX      = 8'h10;
    localparam logic [7:0]  MODE_MAX       = 8'h03;
    localparam logic [1:0]  MODE_OVERWRITE = 2'h0;
    localparam logic [1:0]  MODE_ARCHIVE   = 2'h1;
    localparam logic [1:0]  MODE_APPEND    = 2'h2;
    localparam logic [1:0]  MODE_TRANSIENT = 2'h3;
    localparam int unsigned CLK_HZ         = 40000000;
    localparam int unsigned DRSP_TIMEOUT_MS = 5000;
    localparam int unsigned DRSP_TIMEOUT_CYC = (CLK_HZ / 1000) * DRSP_TIMEOUT_MS;
    localparam int unsigned TIMER_W        = 28;
    typedef enum logic [2:0] {
        S_IDLE,
        S_LEN_HI,
        S_LEN_LO,
        S_BODY,
        S_CSUM
    } hafb_state_t;
endpackage

// ### rtl/hafb_csum.sv
// Running checksum of the frame bytes from the type byte to the last payload byte.
`timescale 1ns/1ps
`default_nettype none
module hafb_csum (
    input  wire logic       clk_sys_i,
    input  wire logic       rstn_i,
    input  wire logic       clr_i,
    input  wire logic       add_i,
    input  wire logic [7:0] byte_i,
    output logic      [7:0] expect_o
);
    logic [7:0] sum_r;

    // Only the low eight bits matter, so the carry is dropped on purpose.
    always_ff @(posedge clk_sys_i or negedge rstn_i) begin
        if (!rstn_i) begin
            sum_r <= 8'h00;
        end else if (clr_i) begin
            sum_r <= 8'h00;
        end else if (add_i) begin
            sum_r <= sum_r + byte_i;
        end
    end

    assign expect_o = hafb_pkg::CSUM_BASE - sum_r;
endmodule
`default_nettype wire

// ### tb/hafb_host_model.sv
// Host-side model that wraps a frame body in delimiter, length and checksum and strobes it out.
`timescale 1ns/1ps
`default_nettype none
module hafb_host_model (
    input  wire logic       clk_sys_i,
    output logic            valid_o,
    output logic      [7:0] byte_o
);
    initial begin
        valid_o = 1'b0;
        byte_o  = 8'h00;
    end
    // A set bad_i spoils the checksum on purpose. The idle byte is inverted so stale data never looks valid.
    task automatic send(input logic [7:0] body[$], input logic bad_i);
        logic [7:0] sum;
        logic [7:0] fr[$];
        sum = 8'h00;
        foreach (body[i]) sum = sum + body[i];
        fr = {8'h7E, 8'(body.size() >> 8), 8'(body.size())};
        fr = {fr, body, (8'hFF - sum) ^ {7'h00, bad_i}};
        foreach (fr[i]) begin
            @(posedge clk_sys_i);
            valid_o <= 1'b1;
            byte_o  <= fr[i];
        end
        @(posedge clk_sys_i);
        valid_o <= 1'b0;
        byte_o  <= ~fr[fr.size()-1];
    endtask
    // A lone byte outside any frame, which the receiver has to drop.
    task automatic noise(input logic [7:0] b);
        @(posedge clk_sys_i);
        valid_o <= 1'b1;
        byte_o  <= b;
        @(posedge clk_sys_i);
        valid_o <= 1'b0;
        byte_o  <= ~b;
    endtask
endmodule
`default_nettype wire

// ### tb/host_api_frame_builder_tb.sv
// Self-checking testbench of the host API frame receiver with a queue scoreboard.
`timescale 1ns/1ps
`default_nettype none
module host_api_frame_builder_tb;
    localparam int TO = 50;
    localparam logic [79:0] CT = "text/plain";
    typedef struct packed {
        logic [7:0] typ; logic good; logic [7:0] fid; logic tcp; logic cls; logic [15:0] sp;
        logic tl; logic oe; logic [1:0] md; logic ce; logic mm; logic ux;
    } hafb_exp_t;
    logic clk_sys_i = 1'b0;
    logic rstn_i = 1'b0;
    logic dev_req_i = 1'b0;
    logic [7:0] dev_req_id_i = 8'h00;
    logic in_valid_i;
    logic [7:0] in_byte_i;
    logic done_o, good_o, status_wanted_o, tx4_tcp_o, tx4_close_o, tx4_too_long_o, opt_err_o;
    logic sd_ctype_err_o, dr_mismatch_o, dr_unexpected_o, dr_timeout_o, data_valid_o;
    logic [7:0] type_o, fid_o, data_o, rnd, pid;
    logic [15:0] tx4_srcport_o;
    logic [1:0] sd_mode_o;
    logic [7:0] q[$];
    logic [7:0] dq[$];
    hafb_exp_t eq[$];
    hafb_exp_t e;
    logic pend;
    int n_fail = 0, n_compared = 0, cyc = 0, t0 = 0;
    always #12.5 clk_sys_i = ~clk_sys_i;
    always @(posedge clk_sys_i) cyc <= cyc + 1;
    hafb_host_model i_host (.clk_sys_i(clk_sys_i), .valid_o(in_valid_i), .byte_o(in_byte_i));
    hafb_frame_rx #(.TIMEOUT_CYC(TO)) i_dut (
        .clk_sys_i(clk_sys_i), .rstn_i(rstn_i), .in_valid_i(in_valid_i), .in_byte_i(in_byte_i),
        .dev_req_i(dev_req_i), .dev_req_id_i(dev_req_id_i), .done_o(done_o), .good_o(good_o),
        .type_o(type_o), .fid_o(fid_o), .status_wanted_o(status_wanted_o), .tx4_tcp_o(tx4_tcp_o),
        .tx4_close_o(tx4_close_o), .tx4_srcport_o(tx4_srcport_o), .tx4_too_long_o(tx4_too_long_o),
        .opt_err_o(opt_err_o), .sd_mode_o(sd_mode_o), .sd_ctype_err_o(sd_ctype_err_o),
        .dr_mismatch_o(dr_mismatch_o), .dr_unexpected_o(dr_unexpected_o), .dr_timeout_o(dr_timeout_o),
        .data_valid_o(data_valid_o), .data_o(data_o));
    function automatic logic [7:0] rnd8();
        rnd = {rnd[6:0], 1'b0} ^ (rnd[7] ? 8'h1D : 8'h00);
        return rnd;
    endfunction
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("BAD t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask
    task automatic stop_test();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    task automatic data(input int n);
        logic [7:0] d;
        repeat (n) begin
            d = rnd8();
            q.push_back(d);
            dq.push_back(d);
        end
    endtask
    task automatic tx4(input logic [7:0] fid, input logic [15:0] sp, input logic [7:0] pr,
                       input logic [7:0] op, input int n, input logic bad);
        q = {8'h20, fid};
        repeat (6) q.push_back(rnd8());
        q = {q, sp[15:8], sp[7:0], pr, op};
        data(n);
        e = '0; e.typ = 8'h20; e.good = !bad; e.fid = fid; e.tcp = (pr == 8'h01); e.cls = e.tcp & op[1];
        e.sp = sp; e.tl = (n > 1400); e.oe = ((op & 8'hFD) != 8'h00);
        eq.push_back(e);
        i_host.send(q, bad);
    endtask
    task automatic sd(input logic [7:0] fid, input logic [7:0] ctl, input logic [7:0] md, input int n);
        q = {8'h28, fid, 8'h02, 8'h61, 8'h62, ctl};
        for (int k = 0; k < ctl; k++) q.push_back(CT[79 - 8 * (k % 10) -: 8]);
        q = {q, 8'h00, md};
        data(n);
        e = '0; e.typ = 8'h28; e.good = 1'b1; e.fid = fid; e.md = md[1:0];
        e.ce = (ctl > 8'h10); e.oe = (md > 8'h03);
        eq.push_back(e);
        i_host.send(q, 1'b0);
    endtask
    task automatic dr(input logic [7:0] fid, input logic [7:0] id, input logic [7:0] rs, input int n);
        q = {8'h2A, fid, id, rs};
        data(n);
        e = '0; e.typ = 8'h2A; e.good = 1'b1; e.fid = fid; e.oe = (rs != 8'h00);
        e.mm = pend && (id != pid); e.ux = !pend;
        if (pend && id == pid) pend = 1'b0;
        eq.push_back(e);
        i_host.send(q, 1'b0);
    endtask
    task automatic req(input logic [7:0] id);
        @(posedge clk_sys_i);
        dev_req_i <= 1'b1;
        dev_req_id_i <= id;
        @(posedge clk_sys_i);
        dev_req_i <= 1'b0;
        #1;
        t0 = cyc;
        pend = (id != 8'h00);
        pid = id;
    endtask
    always begin
        @(posedge clk_sys_i);
        #1;
        if (data_valid_o === 1'b1) begin
            if (dq.size() == 0) check(1, 0);
            else check(data_o, dq.pop_front());
        end
        if (done_o === 1'b1) begin
            if (eq.size() == 0) check(1, 0);
            else begin
                e = eq.pop_front();
                check(good_o, e.good);
                check(type_o, e.typ);
                if (e.good) begin
                    check(fid_o, e.fid);
                    check(status_wanted_o, e.fid != 8'h00);
                    check(opt_err_o, e.oe);
                    if (e.typ == 8'h20) check({tx4_tcp_o, tx4_close_o}, {e.tcp, e.cls});
                    if (e.typ == 8'h20) check({tx4_srcport_o, tx4_too_long_o}, {e.sp, e.tl});
                    if (e.typ == 8'h28) check({sd_mode_o, sd_ctype_err_o}, {e.md, e.ce});
                    if (e.typ == 8'h2A) check({dr_mismatch_o, dr_unexpected_o}, {e.mm, e.ux});
                end
            end
        end
    end
    initial begin
        repeat (20000) @(posedge clk_sys_i);
        n_fail++;
        stop_test();
    end
    initial begin
        int k;
        rnd = 8'h4C;
        pend = 1'b0;
        pid = 8'h00;
        repeat (2) @(posedge clk_sys_i);
        rstn_i <= 1'b1;
        tx4(8'h01, 16'h0000, 8'h01, 8'h02, 5, 1'b0);
        tx4(8'h00, 16'h2616, 8'h00, 8'h06, 3, 1'b0);
        tx4(8'h7F, 16'h0000, 8'h01, 8'h00, 1400, 1'b0);
        tx4(8'h03, 16'h0000, 8'h01, 8'h00, 1401, 1'b0);
        tx4(8'h05, 16'h1234, 8'h01, 8'h02, 2, 1'b1);
        e = '0; e.typ = 8'h55;
        eq.push_back(e);
        q = {8'h55, 8'h01};
        i_host.send(q, 1'b0);
        // Stray byte between frames, then an empty frame that goes straight to its checksum.
        i_host.noise(rnd8() & 8'h7D);
        e = '0;
        eq.push_back(e);
        q = {};
        i_host.send(q, 1'b0);
        $display("test ipv4 transmit done");
        for (int m = 0; m < 4; m++) sd(8'(m), (m == 0) ? 8'h10 : 8'h0A, 8'(m), 4);
        sd(8'h09, 8'h11, 8'h00, 0);
        sd(8'h0A, 8'h04, 8'h04, 0);
        $display("test send data done");
        req(8'h05);
        dr(8'h01, 8'h05, 8'h00, 5);
        dr(8'h02, 8'h05, 8'h00, 1);
        req(8'h00);
        dr(8'h03, 8'h00, 8'h00, 1);
        req(8'h07);
        dr(8'h00, 8'h05, 8'h01, 2);
        k = 0;
        while (k < 200 && dr_timeout_o !== 1'b1) begin
            @(posedge clk_sys_i);
            #1;
            k++;
        end
        check(cyc - t0, TO);
        pend = 1'b0;
        $display("test device response done");
        repeat (4) @(posedge clk_sys_i);
        check(eq.size() + dq.size(), 0);
        stop_test();
    end
endmodule
`default_nettype wire
